// *** gain_ctrl_pkg.sv ***
// constants and types for the serial gain control port
package gain_ctrl_pkg;
   localparam int FRAME_BITS = 12;
   localparam int ADDR_BITS = 4;
   localparam int DATA_BITS = 8;
   localparam int CNT_BITS = 5;
   localparam logic [CNT_BITS-1:0] FRAME_LEN = 5'h0C;
   localparam logic [CNT_BITS-1:0] CNT_SAT = 5'h1F;
   localparam int NUM_REGS = 8;
   localparam logic [ADDR_BITS-1:0] ADDR_GAIN = 4'h0;
   localparam logic [ADDR_BITS-1:0] ADDR_CTRL = 4'h1;
   localparam logic [ADDR_BITS-1:0] ADDR_ROM = 4'h2;
   localparam logic [ADDR_BITS-1:0] ADDR_LAST = 4'h7;
   localparam int BIAS_HI = 7;
   localparam int BIAS_LO = 6;
   localparam int GAIN_HI = 5;
   localparam int GAIN_LO = 0;
   localparam int PATH_BIT = 2;
   localparam int SWB_BIT = 1;
   localparam int SWA_BIT = 0;
   localparam int LOAD_BIT = 3;
   localparam logic [DATA_BITS-1:0] RESET_VAL = 8'h00;
   localparam logic [1:0] BIAS_FULL = 2'h3;
   localparam logic [5:0] GAIN_MAX = 6'h3F;
   localparam real CLK_MHZ = 50.0;
   localparam real POWERUP_US = 100.0;
   localparam int POWERUP_CYC = int'(POWERUP_US * CLK_MHZ);
   localparam int HALF_DIV = 4;
   localparam int DIV_BITS = 3;
   localparam int CMD_ADDR_BITS = 4;
   localparam logic [CMD_ADDR_BITS-1:0] CMD_FRAME = 4'h0;
   localparam logic [CMD_ADDR_BITS-1:0] CMD_STATUS = 4'h1;
   localparam logic [CMD_ADDR_BITS-1:0] CMD_GATE = 4'h2;
   typedef logic [FRAME_BITS-1:0] frame_t;
   typedef enum {HOST_WAIT, HOST_IDLE, HOST_SETUP, HOST_LOW, HOST_HIGH, HOST_END} host_state_t;
endpackage

// *** gain_link_if.sv ***
// three-wire link between host controller and amplifier control port
`timescale 1ns/100ps
`default_nettype none
interface gain_link_if;
   logic sclk;
   logic sdata;
   logic select_n;
   logic transmit_gate;
   modport host (output sclk, output sdata, output select_n, output transmit_gate);
   modport device (input sclk, input sdata, input select_n, input transmit_gate);
endinterface
`default_nettype wire

// *** gain_ctrl_device.sv ***
// amplifier control port: serial shifter and write-only register bank
`timescale 1ns/100ps
`default_nettype none
module gain_ctrl_device
   import gain_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   gain_link_if.device link,
   output logic [1:0] bias_level,
   output logic [5:0] gain_step,
   output logic output_path_sel,
   output logic first_output_en,
   output logic second_output_en,
   output logic switch_line_a,
   output logic switch_line_b,
   output logic transmit_on,
   output logic table_load_pulse,
   output logic full_linearity,
   output logic max_gain
);
   import gain_ctrl_pkg::*;

   logic [2:0] sclkSync_r;
   logic [2:0] selSync_r;
   logic [1:0] dataSync_r;
   logic [1:0] gateSync_r;
   logic sclkRise;
   logic selRise;
   logic selLow;
   frame_t shift_r;
   logic [CNT_BITS-1:0] count_r;
   logic [DATA_BITS-1:0] regs_r [NUM_REGS];
   logic [1:0] bias_r;
   logic [5:0] gain_r;
   logic loadPrev_r;
   logic loadPulse_r;
   logic gate_r;
   logic commit;
   logic [ADDR_BITS-1:0] frameAddr;
   logic [DATA_BITS-1:0] frameData;

   // only stage 1 and beyond feed logic; stage 0 is the metastable flop
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sclkSync_r <= '0;
         selSync_r <= 3'h7;
         dataSync_r <= '0;
         gateSync_r <= '0;
      end
      else
      begin
         sclkSync_r <= {sclkSync_r[1:0], link.sclk};
         selSync_r <= {selSync_r[1:0], link.select_n};
         dataSync_r <= {dataSync_r[0], link.sdata};
         gateSync_r <= {gateSync_r[0], link.transmit_gate};
      end
   end

   assign sclkRise = sclkSync_r[1] & ~sclkSync_r[2];
   assign selRise = selSync_r[1] & ~selSync_r[2];
   assign selLow = ~selSync_r[1];
   assign frameAddr = shift_r[FRAME_BITS-1 -: ADDR_BITS];
   assign frameData = shift_r[DATA_BITS-1:0];
   assign commit = selRise && (count_r == FRAME_LEN);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         shift_r <= '0;
         count_r <= '0;
      end
      else if (selRise)
      begin
         count_r <= '0;
      end
      else if (selLow && sclkRise)
      begin
         shift_r <= {shift_r[FRAME_BITS-2:0], dataSync_r[1]};
         if (count_r != CNT_SAT)
         begin
            count_r <= count_r + 5'h01;
         end
      end
   end

   // no readback path exists: the bank is only ever written
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs_r[i] <= RESET_VAL;
         end
      end
      else if (commit && frameAddr <= ADDR_LAST)
      begin
         regs_r[frameAddr[2:0]] <= frameData;
      end
   end

   // operating point moves only at the select rising edge, never mid-frame
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         bias_r <= '0;
         gain_r <= '0;
      end
      else if (commit && frameAddr == ADDR_GAIN)
      begin
         bias_r <= frameData[BIAS_HI:BIAS_LO];
         gain_r <= frameData[GAIN_HI:GAIN_LO];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         loadPrev_r <= 1'b0;
         loadPulse_r <= 1'b0;
      end
      else
      begin
         loadPrev_r <= regs_r[ADDR_ROM[2:0]][LOAD_BIT];
         loadPulse_r <= loadPrev_r & ~regs_r[ADDR_ROM[2:0]][LOAD_BIT];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         gate_r <= 1'b0;
      end
      else
      begin
         gate_r <= gateSync_r[1];
      end
   end

   assign bias_level = bias_r;
   assign gain_step = gain_r;
   assign full_linearity = (bias_r == BIAS_FULL);
   assign max_gain = (gain_r == GAIN_MAX);
   assign output_path_sel = regs_r[ADDR_CTRL[2:0]][PATH_BIT];
   assign first_output_en = gate_r & ~regs_r[ADDR_CTRL[2:0]][PATH_BIT];
   assign second_output_en = gate_r & regs_r[ADDR_CTRL[2:0]][PATH_BIT];
   assign switch_line_b = regs_r[ADDR_CTRL[2:0]][SWB_BIT];
   assign switch_line_a = regs_r[ADDR_CTRL[2:0]][SWA_BIT];
   assign transmit_on = gate_r;
   assign table_load_pulse = loadPulse_r;
endmodule
`default_nettype wire

// *** gain_ctrl_host.sv ***
// host controller: shifts register frames out over the three-wire link
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module gain_ctrl_host
   import gain_ctrl_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset,
   gain_link_if.host link,
   input wire logic [CMD_ADDR_BITS-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   import gain_ctrl_pkg::*;

   host_state_t state_r;
   logic [15:0] wait_r;
   logic [DIV_BITS-1:0] div_r;
   logic [CNT_BITS-1:0] bit_r;
   frame_t frame_r;
   logic pending_r;
   frame_t pendFrame_r;
   logic gate_r;
   logic sclk_r;
   logic sel_r;
   logic sdata_r;
   logic [31:0] rdata_r;
   logic busy;
   logic ready;
   logic divDone;

   assign busy = (state_r != HOST_IDLE) || pending_r;
   assign ready = (state_r != HOST_WAIT);
   assign divDone = (div_r == DIV_BITS'(HALF_DIV - 1));

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pending_r <= 1'b0;
         pendFrame_r <= '0;
         gate_r <= 1'b0;
      end
      else
      begin
         if (wr && addr == CMD_FRAME && !busy)
         begin
            pending_r <= 1'b1;
            pendFrame_r <= wdata[FRAME_BITS-1:0];
         end
         // a frame queued while the gate is open must survive until the gate closes
         else if (state_r == HOST_IDLE && pending_r && !gate_r)
         begin
            pending_r <= 1'b0;
         end
         if (wr && addr == CMD_GATE)
         begin
            gate_r <= wdata[0];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_r <= HOST_WAIT;
         wait_r <= '0;
         div_r <= '0;
         bit_r <= '0;
         frame_r <= '0;
         sclk_r <= 1'b0;
         sel_r <= 1'b1;
         sdata_r <= 1'b0;
      end
      else
      begin
         div_r <= divDone ? '0 : div_r + DIV_BITS'(1);
         case (state_r)
            HOST_WAIT:
            begin
               div_r <= '0;
               if (wait_r == 16'(POWERUP_WAIT - 1))
               begin
                  state_r <= HOST_IDLE;
               end
               else
               begin
                  wait_r <= wait_r + 16'h0001;
               end
            end
            HOST_IDLE:
            begin
               div_r <= '0;
               if (pending_r && !gate_r)
               begin
                  frame_r <= pendFrame_r;
                  bit_r <= '0;
                  sel_r <= 1'b0;
                  sdata_r <= pendFrame_r[FRAME_BITS-1];
                  state_r <= HOST_SETUP;
               end
            end
            HOST_SETUP:
            begin
               if (divDone)
               begin
                  sclk_r <= 1'b1;
                  state_r <= HOST_HIGH;
               end
            end
            HOST_HIGH:
            begin
               if (divDone)
               begin
                  sclk_r <= 1'b0;
                  bit_r <= bit_r + 5'h01;
                  frame_r <= {frame_r[FRAME_BITS-2:0], 1'b0};
                  sdata_r <= frame_r[FRAME_BITS-2];
                  state_r <= (bit_r == FRAME_LEN - 5'h01) ? HOST_END : HOST_LOW;
               end
            end
            HOST_LOW:
            begin
               if (divDone)
               begin
                  sclk_r <= 1'b1;
                  state_r <= HOST_HIGH;
               end
            end
            HOST_END:
            begin
               if (divDone)
               begin
                  sel_r <= 1'b1;
                  sdata_r <= 1'b0;
                  state_r <= HOST_IDLE;
               end
            end
            default:
            begin
               state_r <= HOST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rdata_r <= '0;
      end
      else if (rd)
      begin
         if (addr == CMD_STATUS)
         begin
            rdata_r <= {30'h0, ready, busy};
         end
         else if (addr == CMD_GATE)
         begin
            rdata_r <= {31'h0, gate_r};
         end
         else
         begin
            rdata_r <= '0;
         end
      end
      else
      begin
         rdata_r <= '0;
      end
   end

   assign rdata = rdata_r;
   assign link.sclk = sclk_r;
   assign link.sdata = sdata_r;
   assign link.select_n = sel_r;
   assign link.transmit_gate = gate_r;
endmodule
`default_nettype wire

// *** serial_gain_ctrl_regs_properties.sv ***
// link-level checks for the three-wire gain control port
`timescale 1ns/100ps
`default_nettype none
module serial_gain_ctrl_regs_properties
   import gain_ctrl_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic select_n,
   input wire logic transmit_gate
);
   import gain_ctrl_pkg::*;
   logic sclkQ_r;
   logic [4:0] bitCnt_r;
   logic [15:0] upCnt_r;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   always_ff @(posedge ref_clk)
   begin
      sclkQ_r <= sclk;
   end
   always_ff @(posedge ref_clk)
   begin
      if (reset || select_n)
         bitCnt_r <= 5'h0;
      else if (sclk && !sclkQ_r && bitCnt_r != CNT_SAT)
         bitCnt_r <= bitCnt_r + 5'h1;
   end
   // saturates so a long run cannot wrap back under the wait
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         upCnt_r <= 16'h0;
      else if (upCnt_r != 16'hFFFF)
         upCnt_r <= upCnt_r + 16'h1;
   end
   AST_GATE_LOW_IN_FRAME: assert property (!select_n |-> !transmit_gate)
      else $error("frame sent while transmit gate high");
   AST_SCLK_IDLE_LOW: assert property (select_n |-> !sclk)
      else $error("serial clock moves outside a frame");
   AST_SCLK_HIGH_FOUR: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("serial clock high phase not four cycles");
   AST_SDATA_STEADY: assert property (sclk |-> $stable(sdata))
      else $error("data changed while serial clock high");
   AST_SELECT_SETUP: assert property ($fell(select_n) |-> !sclk [*4])
      else $error("serial clock rose too soon after select");
   AST_TWELVE_RISES: assert property ($rose(select_n) |-> bitCnt_r == FRAME_LEN)
      else $error("frame did not carry twelve clock rises");
   AST_POWERUP_WAIT: assert property ($fell(select_n) |-> int'(upCnt_r) >= POWERUP_WAIT - 1)
      else $error("frame started before power-up wait");
   AST_SELECT_HOLD: assert property ($rose(select_n) |-> !$past(sclk, 1) && !$past(sclk, 2))
      else $error("select rose without clock low hold");
endmodule
`default_nettype wire

// *** serial_gain_ctrl_regs_tb.sv ***
// bench: host and device joined, plus a device fed with malformed frames
`timescale 1ns/100ps
`default_nettype none
module serial_gain_ctrl_regs_tb;
   import gain_ctrl_pkg::*;
   localparam int WAIT_CYC = 10;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   wire logic [15:0] outA;
   wire logic [15:0] outB;
   wire logic tlpA;
   int miscompares = 0;
   int nCompared = 0;
   int m0 = 0;
   int m1 = 0;
   int b0 = 0;
   int gt = 0;
   int loads = 0;
   gain_link_if link();
   gain_link_if linkB();
   gain_ctrl_host #(.POWERUP_WAIT(WAIT_CYC)) gain_ctrl_host_inst (.ref_clk(ref_clk), .reset(reset), .link(link),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   gain_ctrl_device gain_ctrl_device_inst (.ref_clk(ref_clk), .reset(reset), .link(link),
      .bias_level(outA[15:14]), .gain_step(outA[13:8]), .output_path_sel(outA[7]), .first_output_en(outA[6]),
      .second_output_en(outA[5]), .switch_line_a(outA[4]), .switch_line_b(outA[3]), .transmit_on(outA[2]),
      .table_load_pulse(tlpA), .full_linearity(outA[1]), .max_gain(outA[0]));
   // second device is driven by the bench so frames of wrong length can reach it
   gain_ctrl_device fault_gain_ctrl_device_inst (.ref_clk(ref_clk), .reset(reset), .link(linkB),
      .bias_level(outB[15:14]), .gain_step(outB[13:8]), .output_path_sel(outB[7]), .first_output_en(outB[6]),
      .second_output_en(outB[5]), .switch_line_a(outB[4]), .switch_line_b(outB[3]), .transmit_on(outB[2]),
      .table_load_pulse(), .full_linearity(outB[1]), .max_gain(outB[0]));
   serial_gain_ctrl_regs_properties #(.POWERUP_WAIT(WAIT_CYC)) props_inst (.ref_clk(ref_clk), .reset(reset),
      .sclk(link.sclk), .sdata(link.sdata), .select_n(link.select_n), .transmit_gate(link.transmit_gate));
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (tlpA === 1'b1)
         loads++;
   function automatic logic [15:0] expOut(input int g, input int c, input int t);
      logic [1:0] b;
      logic [5:0] s;
      b = 2'(g >> 6);
      s = 6'(g);
      return {b, s, 1'(c >> 2), 1'(t & ~(c >> 2)), 1'(t & (c >> 2)), 1'(c), 1'(c >> 1), 1'(t), b == 2'h3, s == 6'h3F};
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      nCompared++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrc(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic idle;
      logic [31:0] s;
      s = 32'h1;
      for (int i = 0; i < 400 && s[0] !== 1'b0; i++)
         rdc(CMD_STATUS, s);
      chk("busy", 16'h0, {15'h0, s[0]});
   endtask
   task automatic post(input logic [3:0] a, input logic [7:0] d);
      idle;
      wrc(CMD_FRAME, {20'h0, a, d});
   endtask
   task automatic settle(input logic [3:0] a, input logic [7:0] d);
      repeat (3) @(posedge ref_clk);
      idle;
      repeat (6) @(posedge ref_clk);
      if (a == 4'h0)
         m0 = d;
      if (a == 4'h1)
         m1 = d;
      chk("outA", expOut(m0, m1, gt), outA);
   endtask
   task automatic frame(input logic [3:0] a, input logic [7:0] d);
      post(a, d);
      settle(a, d);
   endtask
   task automatic bang(input int n, input logic [12:0] f);
      @(posedge ref_clk);
      linkB.select_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         linkB.sdata <= f[i];
         repeat (4) @(posedge ref_clk);
         linkB.sclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         linkB.sclk <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      chk("outB", expOut(b0, 0, 0), outB);
      linkB.select_n <= 1'b1;
      linkB.sdata <= ~linkB.sdata;
      repeat (6) @(posedge ref_clk);
      if (n == 12 && f[11:8] == 4'h0)
         b0 = f[7:0];
      chk("outB", expOut(b0, 0, 0), outB);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      $display("mismatch watchdog expected done seen hang");
      wrap_up;
   end
   initial
   begin
      logic [31:0] s;
      linkB.sclk = 1'b0;
      linkB.sdata = 1'b0;
      linkB.select_n = 1'b1;
      linkB.transmit_gate = 1'b0;
      void'($urandom(4643));
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      frame(4'h2, 8'h00);
      frame(4'h2, 8'h08);
      frame(4'h2, 8'h00);
      chk("loads", 16'h1, 16'(loads));
      for (int a = 1; a < 8; a++)
         frame(4'(a), a == 5 ? 8'h06 : 8'h00);
      for (int b = 0; b < 4; b++)
         frame(4'h0, {b[1:0], 6'(63 - b)});
      for (int i = 0; i < 12; i++)
      begin
         frame(4'h0, 8'($urandom));
         frame(4'h1, 8'($urandom));
      end
      frame(4'h8, 8'hFF);
      wrc(CMD_GATE, 32'h1);
      gt = 1;
      rdc(CMD_GATE, s);
      chk("gate", 16'h1, s[15:0]);
      repeat (6) @(posedge ref_clk);
      chk("outA", expOut(m0, m1, gt), outA);
      post(4'h0, 8'h2A);
      // frame must be held back while the gate is open
      repeat (150) @(posedge ref_clk);
      chk("outA", expOut(m0, m1, gt), outA);
      wrc(CMD_GATE, 32'h0);
      gt = 0;
      settle(4'h0, 8'h2A);
      rdc(CMD_STATUS, s);
      chk("status", 16'h2, {14'h0, s[1:0]});
      repeat (POWERUP_CYC) @(posedge ref_clk);
      bang(12, 13'h0C5);
      bang(11, 13'h03A);
      bang(13, 13'h00C5);
      bang(12, 13'h08C5);
      wrap_up;
   end
endmodule
`default_nettype wire
